// >>> rtl/pit_timer.v
// Periodic interval timer top: counters, mode/status/readout, APB.
// Assumes APB master on clk; dbg_halt is synchronous to clk.
// How it works
// - 20-bit interval and 12-bit elapsed counters
// - Counters advance on master clock divided 16
// - Count from zero, wrap at limit, bump elapsed
// - Wrap sets flag; irq when flag and enable, mask clear
// - Period is limit plus one ticks
// - New limit never clears or restarts counters
// - Acknowledge read returns counts, clears elapsed, flag
// - Snapshot read returns counts, no side effects
// - Elapsed in 31:20, current count in 19:0
// - Run-enable change acts only at count zero
// - Disabled timer finishes period then halts
// - Debug state freezes both counters
// - Reset disabled, limit max, enables clear
// - Flag in status bit 0, sticky until ack
//
// The APB interface to the registers was chosen for this implementation.
`timescale 1ns/100ps
`include "pit_consts.vh"
module pit_timer #(
  parameter LW = `PIT_LIMIT_W,
  parameter EW = `PIT_ELAPSED_W
) (
  // Clock and reset
  input wire clk,
  input wire rst_n,
  // APB slave
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [4:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output wire pready,
  output wire pslverr,
  // Core debug state
  input wire dbg_halt,
  // Interrupt
  output wire irq
);
  reg [LW-1:0] interval_limit_q;
  reg timer_run_enable_q;
  reg interval_irq_enable_q;
  reg [LW-1:0] current_interval_count_q;
  reg [EW-1:0] elapsed_interval_count_q;
  reg interval_reached_flag_q;
  reg active_q;
  reg imask_q;
  wire tick;
  wire wrap;
  wire wr_en;
  wire rd_en;
  wire addr_hit;
  wire ack_read;
  wire [3:0] off;
  wire [31:0] value_word;

  assign off = paddr[3:0];
  assign addr_hit = (paddr[1:0] == 2'b00) &&
    ((paddr[4] == 1'b0) || (off == 4'h0));

  pit_apb_slave #(
    .AW(5)
  ) u_apb (
    .psel(psel),
    .penable(penable),
    .pwrite(pwrite),
    .paddr(paddr),
    .pready(pready),
    .pslverr(pslverr),
    .addr_hit(addr_hit),
    .wr_en(wr_en),
    .rd_en(rd_en)
  );

  // Debug halt stops the divider too, so no tick sneaks through
  pit_prescaler #(
    .DIV(`PIT_DIV),
    .W(`PIT_DIV_W)
  ) u_div (
    .clk(clk),
    .rst_n(rst_n),
    .halt(dbg_halt),
    .tick(tick)
  );

  assign wrap = tick && active_q &&
    (current_interval_count_q == interval_limit_q);
  // Clear on the setup edge, the same edge that captures prdata, so a
  // wrap there is either in the returned value or survives the clear
  assign ack_read = psel && !penable && !pwrite &&
    (paddr == {1'b0, `PIT_OFF_ACK});

  // Mode register; writes leave the counters alone
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      interval_limit_q <= `PIT_LIMIT_RESET;
      timer_run_enable_q <= 1'b0;
      interval_irq_enable_q <= 1'b0;
      imask_q <= 1'b0;
    end else if (wr_en) begin
      if (paddr == {1'b0, `PIT_OFF_MODE}) begin
        interval_limit_q <= pwdata[LW-1:0];
        timer_run_enable_q <= pwdata[`PIT_RUN_BIT];
        interval_irq_enable_q <= pwdata[`PIT_IEN_BIT];
      end else if (paddr == {1'b1, 4'h0}) begin
        imask_q <= pwdata[0];
      end
    end
  end

  // Enable is sampled while the count sits at zero and on each wrap back to zero
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      active_q <= 1'b0;
    end else if (!dbg_halt) begin
      if (current_interval_count_q == {LW{1'b0}} &&
          !(active_q && tick)) begin
        active_q <= timer_run_enable_q;
      end else if (wrap) begin
        active_q <= timer_run_enable_q;
      end
    end
  end

  // Interval counter
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      current_interval_count_q <= {LW{1'b0}};
    end else if (tick && active_q) begin
      if (wrap) begin
        current_interval_count_q <= {LW{1'b0}};
      end else begin
        current_interval_count_q <= current_interval_count_q + 1'b1;
      end
    end
  end

  // Elapsed counter; a wrap in the ack cycle counts as one
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      elapsed_interval_count_q <= {EW{1'b0}};
    end else if (ack_read) begin
      elapsed_interval_count_q <= wrap ? {{(EW-1){1'b0}}, 1'b1}
        : {EW{1'b0}};
    end else if (wrap) begin
      elapsed_interval_count_q <= elapsed_interval_count_q + 1'b1;
    end
  end

  // Sticky flag: set wins over the acknowledge clear
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      interval_reached_flag_q <= 1'b0;
    end else if (wrap) begin
      interval_reached_flag_q <= 1'b1;
    end else if (ack_read) begin
      interval_reached_flag_q <= 1'b0;
    end
  end

  assign irq = interval_reached_flag_q && interval_irq_enable_q &&
    !imask_q;

  assign value_word = {elapsed_interval_count_q,
    current_interval_count_q};

  // Read data register; snapshot read has no side effects
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      prdata <= 32'h00000000;
    end else if (psel && !penable && !pwrite) begin
      case (paddr)
        {1'b0, `PIT_OFF_MODE}: begin
          prdata <= {6'h00, interval_irq_enable_q, timer_run_enable_q,
            4'h0, interval_limit_q};
        end
        {1'b0, `PIT_OFF_STATUS}: begin
          prdata <= {31'h0, interval_reached_flag_q};
        end
        {1'b0, `PIT_OFF_ACK}: begin
          prdata <= value_word;
        end
        {1'b0, `PIT_OFF_SNAP}: begin
          prdata <= value_word;
        end
        {1'b1, 4'h0}: begin
          prdata <= {31'h0, imask_q};
        end
        default: begin
          prdata <= 32'h00000000;
        end
      endcase
    end
  end
endmodule

// >>> rtl/pit_consts.vh
// Constants for the periodic interval timer: offsets, fields, resets.
// Included by the timer top and prescaler design files; definitions only.
`ifndef PIT_CONSTS_VH
`define PIT_CONSTS_VH

// Register byte offsets
`define PIT_OFF_MODE 4'h0
`define PIT_OFF_STATUS 4'h4
`define PIT_OFF_ACK 4'h8
`define PIT_OFF_SNAP 4'hc
`define PIT_OFF_IMASK 5'h10

// Mode register fields
`define PIT_LIMIT_W 20
`define PIT_ELAPSED_W 12
`define PIT_RUN_BIT 24
`define PIT_IEN_BIT 25
`define PIT_MODE_RESET 32'h000fffff
`define PIT_LIMIT_RESET 20'hfffff

// Status fields
`define PIT_FLAG_BIT 0

// Time base: master clock divided by sixteen
`define PIT_DIV 16
`define PIT_DIV_W 4

`endif

// >>> rtl/pit_prescaler.v
// Time-base divider: one-cycle tick every PIT_DIV clocks.
// Assumes a single clock; halt freezes the phase.
`timescale 1ns/100ps
`include "pit_consts.vh"
module pit_prescaler #(
  parameter DIV = `PIT_DIV,
  parameter W = `PIT_DIV_W
) (
  // Clock and reset
  input wire clk,
  input wire rst_n,
  // Control
  input wire halt,
  // Output
  output wire tick
);
  localparam [31:0] LAST_FULL = DIV - 1;
  localparam [W-1:0] LAST = LAST_FULL[W-1:0];
  reg [W-1:0] cnt_q;

  assign tick = !halt && (cnt_q == LAST);

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_q <= {W{1'b0}};
    end else if (!halt) begin
      if (cnt_q == LAST) begin
        cnt_q <= {W{1'b0}};
      end else begin
        cnt_q <= cnt_q + 1'b1;
      end
    end
  end
endmodule

// >>> rtl/pit_apb_slave.v
// APB slave decode: zero wait states, pslverr on unmapped offsets.
// Assumes a well-behaved APB master; word access only.
`timescale 1ns/100ps
module pit_apb_slave #(
  parameter AW = 5
) (
  // APB
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [AW-1:0] paddr,
  output wire pready,
  output wire pslverr,
  // Decoded access
  input wire addr_hit,
  output wire wr_en,
  output wire rd_en
);
  wire access;

  assign access = psel && penable;
  assign pready = 1'b1;
  assign pslverr = access && !addr_hit;
  assign wr_en = access && pwrite && addr_hit;
  assign rd_en = access && !pwrite && addr_hit;
endmodule

// >>> dv/pit_checker.sv
// Checker: APB answers and interrupt behaviour of the interval timer.
// Sees only the top-level ports; bound into pit_timer below.
`timescale 1ns/100ps
module pit_checker (
  // Clock and reset
  input wire clk,
  input wire rst_n,
  // APB
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [4:0] paddr,
  input wire [31:0] pwdata,
  input wire [31:0] prdata,
  input wire pready,
  input wire pslverr,
  // Debug and interrupt
  input wire dbg_halt,
  input wire irq
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  wire acc = psel && penable;
  wire map = paddr[1:0] == 2'h0 && paddr <= 5'h10;
  AST_MAPPED_OK: assert property (acc && map |-> pready && !pslverr)
    else $error("mapped access refused");
  AST_UNMAPPED_ERR: assert property (acc && !map |-> pslverr)
    else $error("unmapped access not refused");
  AST_ERR_DATA: assert property (acc && !map && !pwrite |-> prdata == 32'h0)
    else $error("unmapped read data not zero");
  AST_STATUS_BITS: assert property (
    acc && !pwrite && paddr == 5'h4 |-> prdata[31:1] == 31'h0)
    else $error("status spare bits set");
  AST_IEN_OFF: assert property (
    acc && pwrite && paddr == 5'h0 && !pwdata[25] |=> !irq)
    else $error("irq with enable clear");
  AST_HALT_IRQ: assert property (
    $past(dbg_halt) && !$past(psel) |-> $stable(irq))
    else $error("irq moved while halted");
  AST_RST_IRQ: assert property (
    $rose(rst_n) |-> !irq && prdata == 32'h0)
    else $error("outputs not idle after reset");
  AST_ACK_IRQ: assert property (
    acc && !pwrite && paddr == 5'h8 && dbg_halt |=> !irq)
    else $error("irq kept after acknowledge");
  cover property (acc && !pwrite && paddr == 5'h8);
  cover property ($rose(irq));
  cover property (acc && pslverr);
endmodule

bind pit_timer pit_checker u_chk (.clk(clk), .rst_n(rst_n), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
  .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .dbg_halt(dbg_halt), .irq(irq));

// >>> dv/tb.sv
// Testbench for the interval timer: sequences of APB accesses.
// Drives every timer input itself; no far-side model.
`timescale 1ns/100ps
`define CHK(n, e, g) begin total_checks++; if ((g) !== (e)) begin \
  num_errors++; $display("MISMATCH %s exp %h got %h", n, e, g); end end
module tb;
  reg clk = 0, rst_n = 0, psel = 0, penable = 0, pwrite = 0, dbg_halt = 0;
  reg [4:0] paddr = 0;
  reg [31:0] pwdata = 0, rd, s0;
  reg err;
  wire [31:0] prdata;
  wire pready, pslverr, irq;
  int num_errors = 0, total_checks = 0, i;
  pit_timer u_dut (.clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .dbg_halt(dbg_halt), .irq(irq));
  initial begin
    forever #10 clk = ~clk;
  end
  task apb(input bit w, input [4:0] a, input [31:0] d);
    @(posedge clk);
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1;
    do @(posedge clk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 0;
    penable <= 0;
    // Let the access edge's updates land before callers sample irq
    #1;
  endtask
  task final_report;
    $display("checks %0d mismatches %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge clk);
    num_errors++;
    final_report;
  end
  initial begin
    repeat (16) @(posedge clk);
    rst_n <= 1;
    for (i = 0; i < 4; i++) begin
      apb(0, 5'(4 * i), 0);
      `CHK("reset value", i ? 32'h0 : 32'h000fffff, rd)
    end
    apb(1, 5'h14, 32'hffffffff);
    apb(1, 5'h4, 32'hffffffff);
    apb(0, 5'h14, 0);
    `CHK("unmapped err", 1'b1, err)
    `CHK("unmapped data", 32'h0, rd)
    apb(0, 5'h4, 0);
    `CHK("status ro", 32'h0, rd)
    $display("end reset and map");
    apb(1, 5'h0, 32'h03000003);
    repeat (100) @(posedge clk);
    // Setup edges 64 clocks apart: exactly one period of limit 3
    apb(0, 5'hc, 0);
    s0 = rd;
    repeat (61) @(posedge clk);
    apb(0, 5'hc, 0);
    `CHK("one period", s0 + 32'h00100000, rd)
    `CHK("count bound", 1'b1, rd[19:0] <= 20'h3)
    apb(0, 5'h4, 0);
    `CHK("flag", 32'h1, rd)
    `CHK("irq on", 1'b1, irq)
    apb(1, 5'h10, 1);
    `CHK("irq masked", 1'b0, irq)
    apb(1, 5'h10, 0);
    apb(1, 5'h0, 32'h01000003);
    `CHK("irq ien off", 1'b0, irq)
    apb(1, 5'h0, 32'h03000003);
    `CHK("irq ien on", 1'b1, irq)
    $display("end period and irq");
    @(posedge clk) dbg_halt <= 1;
    apb(0, 5'hc, 0);
    s0 = rd;
    repeat (40) @(posedge clk);
    apb(0, 5'hc, 0);
    `CHK("halt frozen", s0, rd)
    apb(1, 5'h0, 32'h03000007);
    apb(0, 5'hc, 0);
    `CHK("new limit keeps", s0, rd)
    apb(0, 5'h8, 0);
    `CHK("ack value", s0, rd)
    apb(0, 5'hc, 0);
    `CHK("ack clears", {12'h0, s0[19:0]}, rd)
    apb(0, 5'h4, 0);
    `CHK("flag cleared", 32'h0, rd)
    `CHK("irq cleared", 1'b0, irq)
    $display("end halt and ack");
    @(posedge clk) dbg_halt <= 0;
    apb(1, 5'h0, 32'h02000003);
    repeat (200) @(posedge clk);
    apb(0, 5'hc, 0);
    s0 = rd;
    `CHK("stopped at zero", 20'h0, s0[19:0])
    repeat (100) @(posedge clk);
    apb(0, 5'hc, 0);
    `CHK("stays stopped", s0, rd)
    $display("end disable");
    final_report;
  end
endmodule
